// >>> include/sas_defs.svh
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH
`define SAS_OFF_CTRL     12'h000
`define SAS_OFF_RESULT   12'h004
`define SAS_OFF_IRQ_STAT 12'h008
`define SAS_OFF_IRQ_EN   12'h00c
`define SAS_OFF_IRQ_CLR  12'h010
`define SAS_CTRL_RESET   8'hfc
`define SAS_PINS_HI      7
`define SAS_PINS_LO      6
`define SAS_CLK_HI       5
`define SAS_CLK_LO       4
`define SAS_CHAN_HI      3
`define SAS_CHAN_LO      2
`define SAS_GO_BIT       1
`define SAS_ON_BIT       0
`define SAS_CLK_INTERNAL 2'h3
`define SAS_SAMPLE_TICKS 4'h4
`define SAS_INT_DIV      4'h4
`define SAS_IRQ_DONE     0
`define SAS_IRQ_ABORT    1
`define SAS_IRQ_W        2
`endif

// >>> include/sas_pkg.sv
package sas_pkg;
  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_RESOLVE} sas_state_t;
  typedef logic [7:0] sas_byte_t;
endpackage

// >>> rtl/sas_tick_gen.sv
`timescale 1ns/1ps
`include "sas_defs.svh"
module sas_tick_gen (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] lim;
  logic       tick_nxt;
  // conversion clock rate pick
  always_comb begin
    case (sel)
      2'h0:              lim = 4'h1;
      2'h1:              lim = 4'h7;
      2'h2:              lim = 4'h3;
      `SAS_CLK_INTERNAL: lim = `SAS_INT_DIV - 4'h1;
      default:           lim = 4'h1;
    endcase
    tick_nxt = run && (cnt_r >= lim);
    cnt_nxt  = (!run || tick_nxt) ? 4'h0 : cnt_r + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      tick  <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule

// >>> rtl/sas_pin_sync.sv
`timescale 1ns/1ps
`include "sas_defs.svh"
module sas_pin_sync (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// >>> rtl/sas_adc_seq.sv
`timescale 1ns/1ps
`include "sas_defs.svh"
module sas_adc_seq
  import sas_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            comp_out,
  output logic                 conv_power,
  output logic                 sample_en,
  output logic      [1:0]      mux_sel,
  output logic                 mux_ref_sel,
  output sas_pkg::sas_byte_t   trial_code,
  output logic      [2:0]      analog_pin_mode,
  output logic                 irq
);
  ////////////////////////////////////////////////////////////
  sas_state_t      st_r;
  sas_state_t      st_nxt;
  sas_byte_t       ctrl_r;
  sas_byte_t       ctrl_nxt;
  sas_byte_t       res_r;
  sas_byte_t       res_nxt;
  sas_byte_t       acc_r;
  sas_byte_t       acc_nxt;
  logic [3:0]      samp_r;
  logic [3:0]      samp_nxt;
  logic [`SAS_IRQ_W-1:0] stat_r;
  logic [`SAS_IRQ_W-1:0] stat_nxt;
  logic [`SAS_IRQ_W-1:0] en_r;
  logic [`SAS_IRQ_W-1:0] en_nxt;
  logic [`SAS_IRQ_W-1:0] ev;
  logic [31:0]     rd_nxt;
  logic            slverr_nxt;
  logic            wr;
  logic            rd;
  logic            hit;
  logic            tick;
  logic            comp_s;
  logic            run;
  sas_byte_t       wval;
  sas_byte_t       marker_path;
  ////////////////////////////////////////////////////////////
  sas_tick_gen u_tick (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (run),
    .sel   (ctrl_r[`SAS_CLK_HI:`SAS_CLK_LO]),
    .tick  (tick)
  );
  sas_pin_sync u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (comp_out),
    .q     (comp_s)
  );
  assign run = (st_r != SAS_IDLE);
  ////////////////////////////////////////////////////////////
  // apb decode
  always_comb begin
    wr   = psel && penable && pwrite;
    rd   = psel && penable && !pwrite;
    wval = pwdata[7:0];
    hit  = (paddr == `SAS_OFF_CTRL) || (paddr == `SAS_OFF_RESULT) || (paddr == `SAS_OFF_IRQ_STAT) ||
           (paddr == `SAS_OFF_IRQ_EN) || (paddr == `SAS_OFF_IRQ_CLR);
    slverr_nxt = psel && !penable && !(hit);
    rd_nxt = 32'h0;
    case (paddr)
      `SAS_OFF_CTRL:     rd_nxt = {24'h0, ctrl_r};
      `SAS_OFF_RESULT:   rd_nxt = {24'h0, res_r};
      `SAS_OFF_IRQ_STAT: rd_nxt = {30'h0, stat_r};
      `SAS_OFF_IRQ_EN:   rd_nxt = {30'h0, en_r};
      default:           rd_nxt = 32'h0;
    endcase
  end
  ////////////////////////////////////////////////////////////
  // conversion sequencer
  always_comb begin
    st_nxt   = st_r;
    ctrl_nxt = ctrl_r;
    res_nxt  = res_r;
    acc_nxt  = acc_r;
    samp_nxt = samp_r;
    ev       = '0;
    marker_path = {1'b0, res_r[7:1]};
    if (wr && paddr == `SAS_OFF_CTRL) begin
      ctrl_nxt = wval;
      if (!wval[`SAS_ON_BIT])
        ctrl_nxt[`SAS_GO_BIT] = 1'b0;
    end
    case (st_r)
      SAS_IDLE: begin
        if (ctrl_nxt[`SAS_GO_BIT] && ctrl_nxt[`SAS_ON_BIT]) begin
          st_nxt   = SAS_SAMPLE;
          samp_nxt = 4'h0;
        end
      end
      SAS_SAMPLE: begin
        // result untouched while sampling
        if (tick)
          samp_nxt = samp_r + 4'h1;
        if (tick && samp_r == `SAS_SAMPLE_TICKS - 4'h1) begin
          res_nxt = 8'h80;
          acc_nxt = 8'h80;
          st_nxt  = SAS_RESOLVE;
        end
      end
      SAS_RESOLVE: begin
        if (tick) begin
          // decide bit under marker, shift marker right
          res_nxt = (marker_path & ((res_r & ~(res_r - 8'h1)) >> 1)) |
                    (res_r & (res_r - 8'h1)) |
                    ((res_r & ~(res_r - 8'h1)) & {8{comp_s}});
          // next trial: decided bits plus new marker
          acc_nxt = res_nxt;
          if (res_r[0]) begin
            // eighth shift pushes marker out
            ctrl_nxt[`SAS_GO_BIT] = 1'b0;
            st_nxt = SAS_IDLE;
            ev[`SAS_IRQ_DONE] = 1'b1;
          end
        end
      end
      default: st_nxt = SAS_IDLE;
    endcase
    if (run && !ctrl_nxt[`SAS_GO_BIT] && !(st_r == SAS_RESOLVE && tick && res_r[0])) begin
      st_nxt  = SAS_IDLE;
      res_nxt = res_r;
      ev[`SAS_IRQ_ABORT] = 1'b1;
    end
    if (!ctrl_nxt[`SAS_ON_BIT])
      st_nxt = SAS_IDLE;
  end
  ////////////////////////////////////////////////////////////
  // interrupt status, set beats clear
  always_comb begin
    en_nxt   = en_r;
    stat_nxt = stat_r;
    if (wr && paddr == `SAS_OFF_IRQ_EN)
      en_nxt = pwdata[`SAS_IRQ_W-1:0];
    if (wr && paddr == `SAS_OFF_IRQ_CLR)
      stat_nxt = stat_r & ~pwdata[`SAS_IRQ_W-1:0];
    stat_nxt = stat_nxt | ev;
  end
  ////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r            <= SAS_IDLE;
      ctrl_r          <= `SAS_CTRL_RESET;
      res_r           <= 8'h00;
      acc_r           <= 8'h00;
      samp_r          <= 4'h0;
      stat_r          <= '0;
      en_r            <= '0;
      prdata          <= 32'h0;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      conv_power      <= 1'b0;
      sample_en       <= 1'b0;
      mux_sel         <= 2'h0;
      mux_ref_sel     <= 1'b0;
      trial_code      <= 8'h00;
      analog_pin_mode <= 3'h0;
      irq             <= 1'b0;
    end else if (ce) begin
      st_r            <= st_nxt;
      ctrl_r          <= ctrl_nxt;
      res_r           <= res_nxt;
      acc_r           <= acc_nxt;
      samp_r          <= samp_nxt;
      stat_r          <= stat_nxt;
      en_r            <= en_nxt;
      prdata          <= rd ? prdata : rd_nxt;
      pready          <= psel && !penable;
      pslverr         <= slverr_nxt;
      conv_power      <= ctrl_nxt[`SAS_ON_BIT];
      sample_en       <= (st_nxt == SAS_SAMPLE);
      mux_sel         <= ctrl_nxt[`SAS_CHAN_HI:`SAS_CHAN_LO];
      mux_ref_sel     <= (ctrl_nxt[`SAS_CHAN_HI:`SAS_CHAN_LO] == 2'h3);
      trial_code      <= acc_nxt;
      // analog_pin_mode[i] forces pin i analog, comparator left alone
      case (ctrl_nxt[`SAS_PINS_HI:`SAS_PINS_LO])
        2'h0:    analog_pin_mode <= 3'h0;
        2'h1:    analog_pin_mode <= 3'h4;
        2'h2:    analog_pin_mode <= 3'h5;
        2'h3:    analog_pin_mode <= 3'h7;
        default: analog_pin_mode <= 3'h0;
      endcase
      irq             <= |(stat_nxt & en_nxt);
    end
  end
endmodule

// >>> tb/sas_adc_properties.sv
`timescale 1ns/1ps
module sas_adc_props (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_power,
  input wire logic        sample_en,
  input wire logic [1:0]  mux_sel,
  input wire logic        mux_ref_sel,
  input wire logic [2:0]  analog_pin_mode,
  input wire logic        irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic wr_c;
  assign wr_c = psel && penable && pready && pwrite && paddr == 12'h000 && ce;
  ////////////////////////////////////////////////////////////////
  a_setup_ready: assert property (psel && !penable && ce |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_bad_addr: assert property (pready && paddr > 12'h010 |-> pslverr) else $error("no slverr");
  a_ref_route: assert property (mux_ref_sel == (mux_sel == 2'h3)) else $error("ref route");
  a_pin_codes: assert property (analog_pin_mode inside {3'h0, 3'h4, 3'h5, 3'h7}) else $error("pin mode");
  a_off_idle: assert property (!conv_power |-> !sample_en) else $error("sampling unpowered");
  a_chan_write: assert property (wr_c |=> mux_sel == $past(pwdata[3:2])) else $error("channel not taken");
  a_power_write: assert property (wr_c |=> conv_power == $past(pwdata[0])) else $error("power not taken");
  a_sample_len: assert property ($rose(sample_en) |-> sample_en [*6]) else $error("sampling short");
  c_sample: cover property ($fell(sample_en));
  c_slverr: cover property (pslverr);
  c_irq: cover property (irq);
endmodule
bind sas_adc_seq sas_adc_props i_props (.mclk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .conv_power, .sample_en, .mux_sel, .mux_ref_sel, .analog_pin_mode, .irq);

// >>> tb/sas_front_model.sv
`timescale 1ns/1ps
module sas_front_model
  import sas_pkg::*;
#(
  parameter logic [31:0] LVLS = 32'h0
) (
  input wire logic        mclk,
  input wire logic        conv_power,
  input wire logic [1:0]  mux_sel,
  input sas_pkg::sas_byte_t trial_code,
  output logic            comp_out
);
  logic toggle_r;
  logic [7:0] lvl;
  initial toggle_r = 1'b0;
  always @(posedge mclk) toggle_r <= ~toggle_r;
  assign lvl = LVLS[8*mux_sel+:8];
  assign comp_out = conv_power ? (lvl > trial_code) : toggle_r;
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import sas_pkg::*;
  localparam logic [31:0] LVLS = 32'h50f03ca5;
  localparam logic [11:0] PINS = 12'hf60;
  logic mclk, rst_n, ce, psel, penable, pwrite, comp_out, pready, pslverr, conv_power, sample_en, mux_ref_sel, irq;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] mux_sel;
  logic [2:0] analog_pin_mode;
  sas_byte_t trial_code, last;
  int fail_count, samples_checked;
  sas_adc_seq i_sas_adc_seq (.mclk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .comp_out, .conv_power, .sample_en, .mux_sel, .mux_ref_sel, .trial_code, .analog_pin_mode, .irq);
  sas_front_model #(.LVLS(LVLS)) i_sas_front_model (.mclk, .conv_power, .mux_sel, .trial_code, .comp_out);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(negedge mclk);
    while (pready !== 1'b1) begin
      @(negedge mclk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic sas_byte_t sar(input sas_byte_t lvl);
    sas_byte_t r = 8'h00;
    for (int k = 7; k >= 0; k--) if (lvl > (r | (8'h01 << k))) r = r | (8'h01 << k);
    return r;
  endfunction
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic convert(input logic [1:0] ch);
    apb(1'b1, 12'h000, {24'h0, 4'hf, ch, 2'h3});
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, {24'h0, last});
    rd = 32'h2;
    for (int i = 0; i < 200 && rd[1] !== 1'b0; i++) apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    last = sar(LVLS[8*ch+:8]);
    chk(rd, {24'h0, last});
  endtask
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hfc);
    chk({29'h0, analog_pin_mode}, 32'h7);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h000, {24'h0, c[1:0], 6'h3c});
      settle;
      chk({29'h0, analog_pin_mode}, {29'h0, PINS[3*c+:3]});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, c[1:0], 6'h3c});
    end
    apb(1'b1, 12'h000, 32'hfe);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'hfc);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  task automatic t_abort;
    int m;
    sas_byte_t mask;
    apb(1'b1, 12'h000, 32'hf3);
    repeat (30) @(posedge mclk);
    apb(1'b1, 12'h000, 32'hf1);
    apb(1'b0, 12'h004, 32'h0);
    m = 0;
    while (m < 7 && rd[m] !== 1'b1) m++;
    mask = 8'hff << (m + 1);
    chk({31'h0, rd[m]}, 32'h1);
    chk({24'h0, rd[7:0] & mask}, {24'h0, sar(LVLS[7:0]) & mask});
    last = rd[7:0];
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, rd[1]}, 32'h1);
  endtask
  task automatic t_irq;
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h00c, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h0);
    convert(2'h1);
    settle;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h00c, 32'h0);
    settle;
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    settle;
    chk({31'h0, irq}, 32'h0);
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    last = 8'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs;
    for (int ch = 0; ch < 4; ch++) convert(ch[1:0]);
    t_abort;
    t_irq;
    results;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    results;
  end
endmodule
